//--- rtl/usb_test_reset_params.svh
// register indices, field positions, reset values and constants for the
// test-mode and reset block; included by the package and the block.
`ifndef USB_TEST_RESET_PARAMS_SVH
`define USB_TEST_RESET_PARAMS_SVH

// ----------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------
`define IDX_TOP_CONTROL 14'h0004
`define IDX_TEST_SELECT 14'h040f
`define IDX_EP0_CSR 14'h0412
`define IDX_EP0_FIFO 14'h0420
`define IDX_INT_STATUS 14'h0440
`define IDX_INT_ENABLE 14'h0441
`define IDX_DEVICE_CONTROL 14'h0460

// ----------------------------------------
// field positions
// ----------------------------------------
`define TOP_SOFT_RESET 0
`define TS_SE0_NAK 0
`define TS_TEST_J 1
`define TS_TEST_K 2
`define TS_PACKET 3
`define TS_OVR_HS 4
`define TS_OVR_FS 5
`define TS_FIFO_ACCESS 6
`define TS_FORCE_HOST 7
`define CSR_RX_WAITING 0
`define CSR_TX_LOADED 1
`define CSR_RX_SERVICED 6
`define DC_SESSION 0
`define DC_HOST_MODE 2
`define DC_DEVICE_GONE 7
`define INT_EP0 0
`define INT_BUS_RESET 1

// ----------------------------------------
// reset values and constants
// ----------------------------------------
`define RST_TEST_SELECT 8'h00
`define RST_INT_ENABLE 2'h3
`define EP0_FIFO_BYTES 7'h40
`define PID_DATA0 8'hc3
`define CRC16_INIT 16'hffff
`define CRC16_POLY_REFL 16'ha001
`define LINE_SE0 2'h0

`endif

//--- rtl/usb_test_reset_pkg.sv
// types for the test-mode and reset block.
// assumes usb_test_reset_params.svh is on the include path.
`include "usb_test_reset_params.svh"

package usb_test_reset_pkg;

  // ----------------------------------------
  // bus request carrier
  // ----------------------------------------
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [15:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  // ----------------------------------------
  // pattern transmitter states, gray along the path
  // ----------------------------------------
  typedef enum logic [2:0] {
    TX_IDLE = 3'h0,
    TX_PID = 3'h1,
    TX_DATA = 3'h3,
    TX_CRC_LO = 3'h2,
    TX_CRC_HI = 3'h6
  } tx_state_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [7:0] test_sel;
    logic [63:0][7:0] fifo;
    logic [6:0] cpu_ptr;
    logic [6:0] usb_ptr;
    logic tx_loaded;
    logic rx_waiting;
    logic ep0_int_en;
    logic session;
    logic gone;
    logic [1:0] int_status;
    logic [1:0] int_enable;
    tx_state_t tx_state;
    logic [6:0] tx_idx;
    logic [15:0] crc;
    logic [7:0] tx_byte;
    logic tx_valid;
    logic nak;
    logic drive_j;
    logic drive_k;
    logic host_mode;
    logic high_speed;
    logic full_speed;
    logic dma_abort;
    logic irq;
  } state_t;

endpackage : usb_test_reset_pkg

//--- rtl/usb_test_mode_and_reset.sv
// test-mode selection, endpoint 0 loop-back and reset control.
// assumes a classic wishbone master, single transfers only, and a
// phy-side byte transmitter with valid/ready; all inputs synchronous.
// Functional notes
// - test select 0x01: answer every valid in token with nak
// - test select 0x02: drive continuous j until mode left
// - test select 0x04: drive continuous k until mode left
// - packet test resends loaded pattern forever from one load
// - each pattern send gets data0 pid before and crc after
// - write 0x40: copy pointer, reset cpu pointer, flags, interrupt, in order
// - endpoint 0 transmit and receive share one storage area
// - bit 7 forces host, ignoring role input, line state, disconnect
// - forced host follows session bit, survives device disconnect
// - live disconnect status readable at device control bit 7
// - forced host speed comes from override speed bits
// - soft reset bit resets registers, aborts dma, clears itself
// - processor core resets leave this block untouched
// - hardware reset returns every register to default
// - peripheral bus reset outside host mode clears endpoint state, raises interrupt
// - one combined interrupt output
`timescale 1ns/10ps
`include "usb_test_reset_params.svh"

module usb_test_mode_and_reset (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // register bus
  input wire usb_test_reset_pkg::wb_req_t wb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // usb link side
  input wire logic in_token_i,
  input wire logic bus_reset_i,
  input wire logic role_id_input_i,
  input wire logic [1:0] bus_line_condition_i,
  input wire logic far_device_gone_i,
  input wire logic link_high_speed_i,
  input wire logic tx_ready_i,
  output logic nak_o,
  output logic drive_j_o,
  output logic drive_k_o,
  output logic [7:0] tx_byte_o,
  output logic tx_valid_o,
  // role, speed, system
  output logic host_mode_o,
  output logic high_speed_o,
  output logic full_speed_o,
  output logic dma_abort_o,
  output logic irq_o
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ `CRC16_POLY_REFL) : (r >> 1);
    end
    return r;
  endfunction : crc_step

  function automatic usb_test_reset_pkg::state_t reset_state();
    usb_test_reset_pkg::state_t s;
    s = '0;
    s.test_sel = `RST_TEST_SELECT;
    s.int_enable = `RST_INT_ENABLE;
    s.crc = `CRC16_INIT;
    s.tx_state = usb_test_reset_pkg::TX_IDLE;
    return s;
  endfunction : reset_state

  usb_test_reset_pkg::state_t q;
  usb_test_reset_pkg::state_t next_q;

  logic access;
  logic commit;
  logic wr;
  logic [13:0] idx;
  logic [7:0] wb0;
  logic mode_locked;
  logic soft_reset;
  logic [7:0] pkt_byte;

  assign access = wb_i.cyc & wb_i.stb;
  assign commit = access & q.ack;
  assign wr = commit & wb_i.we & wb_i.sel[0];
  assign idx = wb_i.adr[15:2];
  assign wb0 = wb_i.dat[7:0];
  assign mode_locked = |q.test_sel[`TS_PACKET:`TS_SE0_NAK];
  assign soft_reset = wr && idx == `IDX_TOP_CONTROL && wb0[`TOP_SOFT_RESET];
  assign pkt_byte = q.fifo[q.tx_idx[5:0]];

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    next_q = q;
    next_q.ack = access & ~q.ack;
    next_q.nak = 1'b0;
    next_q.dma_abort = 1'b0;
    next_q.gone = far_device_gone_i;

    // read data is sampled when ack rises, held until the next access
    if (access && !q.ack)
    begin
      next_q.rdat = 32'h0;
      if (idx == `IDX_TEST_SELECT)
        next_q.rdat[7:0] = q.test_sel;
      else if (idx == `IDX_EP0_CSR)
      begin
        next_q.rdat[`CSR_RX_WAITING] = q.rx_waiting;
        next_q.rdat[`CSR_TX_LOADED] = q.tx_loaded;
        next_q.rdat[7] = q.ep0_int_en;
        next_q.rdat[14:8] = q.cpu_ptr;
        next_q.rdat[22:16] = q.usb_ptr;
      end
      else if (idx == `IDX_EP0_FIFO)
        next_q.rdat[7:0] = q.fifo[q.cpu_ptr[5:0]];
      else if (idx == `IDX_INT_STATUS)
        next_q.rdat[1:0] = q.int_status;
      else if (idx == `IDX_INT_ENABLE)
        next_q.rdat[1:0] = q.int_enable;
      else if (idx == `IDX_DEVICE_CONTROL)
      begin
        next_q.rdat[`DC_SESSION] = q.session;
        next_q.rdat[`DC_HOST_MODE] = q.host_mode;
        next_q.rdat[`DC_DEVICE_GONE] = q.gone;
      end
    end

    // reading the fifo pops through the cpu pointer
    if (commit && !wb_i.we && idx == `IDX_EP0_FIFO && q.cpu_ptr < `EP0_FIFO_BYTES)
      next_q.cpu_ptr = q.cpu_ptr + 7'h1;

    if (wr)
    begin
      if (idx == `IDX_TEST_SELECT)
      begin
        if (!mode_locked)
          next_q.test_sel = wb0 & ~(8'h1 << `TS_FIFO_ACCESS);
        if (wb0[`TS_FIFO_ACCESS])
        begin
          next_q.usb_ptr = q.cpu_ptr;
          next_q.cpu_ptr = 7'h0;
          next_q.tx_loaded = 1'b0;
          next_q.rx_waiting = 1'b1;
          if (q.ep0_int_en)
            next_q.int_status[`INT_EP0] = 1'b1;
        end
      end
      else if (idx == `IDX_EP0_CSR)
      begin
        if (wb0[`CSR_TX_LOADED])
          next_q.tx_loaded = 1'b1;
        if (wb0[`CSR_RX_SERVICED])
        begin
          next_q.rx_waiting = 1'b0;
          next_q.usb_ptr = 7'h0;
        end
        next_q.ep0_int_en = wb0[7];
      end
      else if (idx == `IDX_EP0_FIFO)
      begin
        if (q.cpu_ptr < `EP0_FIFO_BYTES)
        begin
          next_q.fifo[q.cpu_ptr[5:0]] = wb0;
          next_q.cpu_ptr = q.cpu_ptr + 7'h1;
        end
      end
      else if (idx == `IDX_INT_STATUS)
        next_q.int_status = q.int_status & ~wb0[1:0];
      else if (idx == `IDX_INT_ENABLE)
        next_q.int_enable = wb0[1:0];
      else if (idx == `IDX_DEVICE_CONTROL)
        next_q.session = wb0[`DC_SESSION];
    end

    if (bus_reset_i && !q.host_mode)
    begin
      next_q.cpu_ptr = 7'h0;
      next_q.usb_ptr = 7'h0;
      next_q.tx_loaded = 1'b0;
      next_q.rx_waiting = 1'b0;
      next_q.int_status[`INT_BUS_RESET] = 1'b1;
    end

    // ----------------------------------------
    // pattern transmitter
    // ----------------------------------------
    case (q.tx_state)
      usb_test_reset_pkg::TX_IDLE:
      begin
        if (q.test_sel[`TS_PACKET] && q.tx_loaded)
        begin
          next_q.tx_state = usb_test_reset_pkg::TX_PID;
          next_q.tx_byte = `PID_DATA0;
          next_q.tx_valid = 1'b1;
        end
      end
      usb_test_reset_pkg::TX_PID:
      begin
        if (tx_ready_i)
        begin
          next_q.crc = `CRC16_INIT;
          next_q.tx_idx = 7'h0;
          next_q.tx_state = usb_test_reset_pkg::TX_DATA;
          if (q.cpu_ptr == 7'h0)
          begin
            next_q.tx_state = usb_test_reset_pkg::TX_CRC_LO;
            next_q.tx_byte = ~q.crc[7:0] & 8'h00 | 8'h00;
          end
          else
          begin
            next_q.tx_byte = q.fifo[0];
            next_q.crc = crc_step(`CRC16_INIT, q.fifo[0]);
            next_q.tx_idx = 7'h1;
          end
        end
      end
      usb_test_reset_pkg::TX_DATA:
      begin
        if (tx_ready_i)
        begin
          if (q.tx_idx >= q.cpu_ptr)
          begin
            next_q.tx_state = usb_test_reset_pkg::TX_CRC_LO;
            next_q.tx_byte = ~q.crc[7:0];
          end
          else
          begin
            next_q.tx_byte = pkt_byte;
            next_q.crc = crc_step(q.crc, pkt_byte);
            next_q.tx_idx = q.tx_idx + 7'h1;
          end
        end
      end
      usb_test_reset_pkg::TX_CRC_LO:
      begin
        if (tx_ready_i)
        begin
          next_q.tx_state = usb_test_reset_pkg::TX_CRC_HI;
          next_q.tx_byte = ~q.crc[15:8];
        end
      end
      usb_test_reset_pkg::TX_CRC_HI:
      begin
        if (tx_ready_i)
        begin
          if (q.test_sel[`TS_PACKET])
          begin
            next_q.tx_state = usb_test_reset_pkg::TX_PID;
            next_q.tx_byte = `PID_DATA0;
          end
          else
          begin
            next_q.tx_state = usb_test_reset_pkg::TX_IDLE;
            next_q.tx_valid = 1'b0;
          end
        end
      end
      default:
      begin
        next_q.tx_state = usb_test_reset_pkg::TX_IDLE;
        next_q.tx_valid = 1'b0;
      end
    endcase

    // ----------------------------------------
    // link modes, role and speed
    // ----------------------------------------
    // nak every in
    next_q.nak = q.test_sel[`TS_SE0_NAK] & in_token_i;
    next_q.drive_j = q.test_sel[`TS_TEST_J];
    next_q.drive_k = q.test_sel[`TS_TEST_K];
    if (q.test_sel[`TS_FORCE_HOST])
    begin
      next_q.host_mode = q.session;
      next_q.high_speed = q.test_sel[`TS_OVR_HS];
      next_q.full_speed = ~q.test_sel[`TS_OVR_HS] & q.test_sel[`TS_OVR_FS];
    end
    else
    begin
      next_q.host_mode = q.session & ~role_id_input_i & ~far_device_gone_i
                         & (bus_line_condition_i != `LINE_SE0);
      next_q.high_speed = link_high_speed_i;
      next_q.full_speed = ~link_high_speed_i;
    end

    next_q.irq = |(next_q.int_status & q.int_enable);

    if (soft_reset)
    begin
      next_q = reset_state();
      next_q.dma_abort = 1'b1;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // no core-reset input reaches this block
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= reset_state();
    else if (ce_i)
      q <= next_q;
  end

  // ----------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------
  assign wb_dat_o = q.rdat;
  assign wb_ack_o = q.ack;
  assign nak_o = q.nak;
  assign drive_j_o = q.drive_j;
  assign drive_k_o = q.drive_k;
  assign tx_byte_o = q.tx_byte;
  assign tx_valid_o = q.tx_valid;
  assign host_mode_o = q.host_mode;
  assign high_speed_o = q.high_speed;
  assign full_speed_o = q.full_speed;
  assign dma_abort_o = q.dma_abort;
  assign irq_o = q.irq;

endmodule : usb_test_mode_and_reset

//--- tb/usb_test_mode_and_reset_sva.sv
// port assertions for the test-mode and reset block.
// assumes ce_i is held high; bound to every instance.
`timescale 1ns/10ps
`include "usb_test_reset_params.svh"
module usb_test_mode_and_reset_sva (
  // clock, reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register bus
  input wire usb_test_reset_pkg::wb_req_t wb_i,
  input wire logic wb_ack_o,
  // link and system
  input wire logic in_token_i,
  input wire logic tx_ready_i,
  input wire logic nak_o,
  input wire logic drive_j_o,
  input wire logic drive_k_o,
  input wire logic [7:0] tx_byte_o,
  input wire logic tx_valid_o,
  input wire logic host_mode_o,
  input wire logic dma_abort_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack held past one cycle");
  property p_ack_answer;
    wb_i.cyc && wb_i.stb && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer)
    else $error("request not answered next cycle");
  property p_nak_cause;
    nak_o |-> $past(in_token_i);
  endproperty
  a_nak_cause: assert property (p_nak_cause)
    else $error("nak without token");
  // a line mode only ends through a soft reset
  property p_mode_hold;
    drive_j_o || drive_k_o |=> $stable({drive_j_o, drive_k_o}) || dma_abort_o;
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("line drive changed");
  property p_pid_first;
    $rose(tx_valid_o) |-> tx_byte_o == `PID_DATA0;
  endproperty
  a_pid_first: assert property (p_pid_first)
    else $error("pattern does not open with data0");
  property p_tx_hold;
    tx_valid_o && !tx_ready_i |=> (tx_valid_o && $stable(tx_byte_o)) || dma_abort_o;
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("byte lost while stalled");
  property p_abort_cause;
    dma_abort_o |-> $past(wb_ack_o && wb_i.we && wb_i.sel[0] && wb_i.dat[0]
      && wb_i.adr[15:2] == `IDX_TOP_CONTROL) ##1 !dma_abort_o;
  endproperty
  a_abort_cause: assert property (p_abort_cause)
    else $error("abort pulse wrong");
  property p_abort_clears;
    dma_abort_o |-> !irq_o && !tx_valid_o && !host_mode_o && !drive_j_o && !drive_k_o;
  endproperty
  a_abort_clears: assert property (p_abort_clears)
    else $error("state survived soft reset");
  property p_reset_defaults;
    $fell(rst_i) |-> !wb_ack_o && !irq_o && !nak_o && !tx_valid_o && !host_mode_o;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("outputs not at default after reset");
endmodule : usb_test_mode_and_reset_sva

bind usb_test_mode_and_reset usb_test_mode_and_reset_sva sva (.clk_i, .rst_i, .wb_i,
  .wb_ack_o, .in_token_i, .tx_ready_i, .nak_o, .drive_j_o, .drive_k_o, .tx_byte_o,
  .tx_valid_o, .host_mode_o, .dma_abort_o, .irq_o);

//--- tb/usb_host_model.sv
// host stand-in: sends in tokens, counts naks, takes pattern bytes.
// assumes the bench enables tokens and picks the pacing.
`timescale 1ns/10ps
module usb_host_model (
  // clock
  input wire logic clk_i,
  // bench control
  input wire logic slow_i,
  input wire logic tok_en_i,
  // link
  input wire logic nak_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic tx_valid_i,
  output logic in_token_o,
  output logic tx_ready_o
);
  logic [7:0] rx_q[$];
  logic phase = 1'b0;
  int tok_cnt = 0;
  int nak_cnt = 0;
  always @(posedge clk_i)
  begin
    phase <= ~phase;
    in_token_o <= tok_en_i & phase;
    tok_cnt <= tok_cnt + int'(in_token_o);
    nak_cnt <= nak_cnt + int'(nak_i);
    if (tx_valid_i && tx_ready_o)
      rx_q.push_back(tx_byte_i);
  end
  // stalling every other cycle exercises the byte hold
  assign tx_ready_o = ~slow_i | phase;
endmodule : usb_host_model

//--- tb/usb_test_mode_and_reset_test.sv
// self-checking bench for the test-mode and reset block.
// assumes the package and params header are compiled first.
`timescale 1ns/10ps
`include "usb_test_reset_params.svh"
module usb_test_mode_and_reset_test;
  localparam logic [15:0] A_TOP = {`IDX_TOP_CONTROL, 2'b00};
  localparam logic [15:0] A_TS = {`IDX_TEST_SELECT, 2'b00};
  localparam logic [15:0] A_CSR = {`IDX_EP0_CSR, 2'b00};
  localparam logic [15:0] A_FIFO = {`IDX_EP0_FIFO, 2'b00};
  localparam logic [15:0] A_IST = {`IDX_INT_STATUS, 2'b00};
  localparam logic [15:0] A_IEN = {`IDX_INT_ENABLE, 2'b00};
  localparam logic [15:0] A_DC = {`IDX_DEVICE_CONTROL, 2'b00};
  logic clk_i, rst_i, tok, slow, bus_reset_i, role_id_input_i, far_device_gone_i;
  logic [1:0] bus_line_condition_i;
  usb_test_reset_pkg::wb_req_t wb_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, in_token_i, tx_ready_i, nak_o, drive_j_o, drive_k_o, tx_valid_o;
  logic host_mode_o, high_speed_o, full_speed_o, irq_o;
  logic [7:0] tx_byte_o;
  logic [7:0] exp_b [56];
  logic [15:0] crc;
  int checks = 0;
  int fail_count = 0;
  int cycles = 0;
  logic [7:0] modes [2] = '{8'h02, 8'h04};
  logic [7:0] fh [3] = '{8'h90, 8'ha0, 8'h80};
  logic [2:0] fhx [3] = '{3'b110, 3'b101, 3'b100};

  usb_test_mode_and_reset dut (.clk_i, .rst_i, .ce_i(1'b1), .wb_i, .wb_dat_o, .wb_ack_o,
    .in_token_i, .bus_reset_i, .role_id_input_i, .bus_line_condition_i, .far_device_gone_i,
    .link_high_speed_i(1'b0), .tx_ready_i, .nak_o, .drive_j_o, .drive_k_o, .tx_byte_o,
    .tx_valid_o, .host_mode_o, .high_speed_o, .full_speed_o, .dma_abort_o(), .irq_o);
  usb_host_model host (.clk_i, .slow_i(slow), .tok_en_i(tok), .nak_i(nak_o),
    .tx_byte_i(tx_byte_o), .tx_valid_i(tx_valid_o), .in_token_o(in_token_i),
    .tx_ready_o(tx_ready_i));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // single classic cycle, released only at the ack edge
  task automatic wb(input logic we, input logic [15:0] a, input logic [31:0] d,
    output logic [31:0] rd);
    wb_i <= '{1'b1, 1'b1, we, a, 4'hf, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1)
      @(posedge clk_i);
    rd = wb_dat_o;
    wb_i <= '0;
    @(posedge clk_i);
  endtask : wb
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] x;
    wb(1'b1, a, d, x);
  endtask : wr
  task automatic rc(input string what, input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] x;
    wb(1'b0, a, 32'h0, x);
    check(what, x, exp);
  endtask : rc
  task automatic pulse_bus_reset();
    bus_reset_i <= 1'b1;
    @(posedge clk_i);
    bus_reset_i <= 1'b0;
  endtask : pulse_bus_reset
  function automatic logic [7:0] pat(input int i);
    logic [127:0] tail;
    tail = 128'h7fbfdfeff7fbfdfc7ebfdfeff7fbfd7e;
    if (i < 9) return 8'h00;
    if (i < 17) return 8'haa;
    if (i < 25) return 8'hee;
    if (i == 25) return 8'hfe;
    if (i < 37) return 8'hff;
    return tail[8*(52-i) +: 8];
  endfunction : pat

  // ----------------------------------------
  // clock, timeout, sequence
  // ----------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      report_and_stop();
    end
  end
  initial
  begin
    rst_i = 1'b1;
    wb_i = '0;
    tok = 1'b0;
    slow = 1'b0;
    bus_reset_i = 1'b0;
    role_id_input_i = 1'b0;
    bus_line_condition_i = 2'h1;
    far_device_gone_i = 1'b0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rc("test_select", A_TS, 32'h0);
    rc("int_enable", A_IEN, 32'h3);
    rc("unmapped", 16'h0000, 32'h0);
    wr(A_TS, 32'h1);
    tok <= 1'b1;
    repeat (10) @(posedge clk_i);
    tok <= 1'b0;
    repeat (3) @(posedge clk_i);
    check("nak count", host.nak_cnt, host.tok_cnt);
    check("tokens sent", host.tok_cnt > 0, 1'b1);
    wr(A_TS, 32'h2);
    rc("locked select", A_TS, 32'h1);
    wr(A_TOP, 32'h1);
    rc("soft reset bit", A_TOP, 32'h0);
    rc("select cleared", A_TS, 32'h0);
    foreach (modes[i])
    begin
      wr(A_TS, 32'(modes[i]));
      @(posedge clk_i);
      check("line drive", {drive_k_o, drive_j_o}, modes[i][2:1]);
      wr(A_TOP, 32'h1);
      @(posedge clk_i);
      check("line drive off", {drive_k_o, drive_j_o}, 2'b00);
    end
    for (int i = 0; i < 3; i++) wr(A_FIFO, 32'h5a + i);
    wr(A_CSR, 32'h82);
    wr(A_TS, 32'h40);
    rc("ep0 status", A_CSR, 32'h0003_0081);
    check("ep0 irq", irq_o, 1'b1);
    for (int i = 0; i < 3; i++) rc("loop byte", A_FIFO, 32'h5a + i);
    wr(A_CSR, 32'h40);
    rc("ep0 serviced", A_CSR, 32'h0000_0300);
    crc = `CRC16_INIT;
    for (int i = 0; i < 53; i++)
    begin
      exp_b[i+1] = pat(i);
      crc ^= {8'h00, pat(i)};
      for (int b = 0; b < 8; b++) crc = crc[0] ? (crc >> 1) ^ `CRC16_POLY_REFL : crc >> 1;
    end
    exp_b[0] = `PID_DATA0;
    exp_b[54] = ~crc[7:0];
    exp_b[55] = ~crc[15:8];
    wr(A_TOP, 32'h1);
    slow <= 1'b1;
    // load pattern, select packet mode, then mark loaded
    for (int i = 0; i < 53; i++) wr(A_FIFO, 32'(pat(i)));
    wr(A_TS, 32'h8);
    wr(A_CSR, 32'h2);
    while (host.rx_q.size() < 112) @(posedge clk_i);
    for (int i = 0; i < 112; i++) check("pattern", host.rx_q[i], exp_b[i % 56]);
    wr(A_TOP, 32'h1);
    // no transmit dma channel open to tear down
    pulse_bus_reset();
    rc("bus reset status", A_IST, 32'h2);
    check("irq raised", irq_o, 1'b1);
    wr(A_IST, 32'h2);
    @(posedge clk_i);
    check("irq cleared", irq_o, 1'b0);
    wr(A_IEN, 32'h0);
    pulse_bus_reset();
    rc("second bus reset", A_IST, 32'h2);
    check("irq masked", irq_o, 1'b0);
    // setup again after the last bus reset
    wr(A_IEN, 32'h3);
    rc("int_enable restored", A_IEN, 32'h3);
    role_id_input_i <= 1'b1;
    bus_line_condition_i <= `LINE_SE0;
    foreach (fh[i])
    begin
      far_device_gone_i <= 1'b0;
      wr(A_TOP, 32'h1);
      wr(A_TS, 32'(fh[i]));
      wr(A_DC, 32'h1);
      far_device_gone_i <= 1'b1;
      @(posedge clk_i);
      rc("device control", A_DC, 32'h85);
      check("forced host", {host_mode_o, high_speed_o, full_speed_o}, fhx[i]);
      wr(A_DC, 32'h0);
      repeat (2) @(posedge clk_i);
      check("session off", host_mode_o, 1'b0);
    end
    report_and_stop();
  end
endmodule : usb_test_mode_and_reset_test
